/* File: rtl/shader_alu_operand_ops.sv */
// Purpose: shader execution datapath with scoreboard and predication
// Assumes: one instruction slot, results written one cycle after issue
// Notes: arithmetic is integer; float only shapes immediate decode
// Operation
// RQ1: vector immediate is eight signed 4-bit elements, -8 to +7
// RQ2: element 0 in bits 3:0, element 7 in bits 31:28
// RQ3: sixteen-channel ops repeat the eight elements per half
// RQ4: float destination converts elements to float, nibble f gives -1
// RQ5: predicated move writes only channels with flag set
// RQ6: predicated select takes source 0 where flag set, else source 1
// RQ7: skip-clear option checks destination but leaves scoreboard bit set
// RQ8: skip-clear plus skip-check neither checks nor clears the bit
// RQ9: skip-check alone issues unchecked, clears bit at completion
// RQ10: four-way dot product result replicated into enabled channels
// RQ11: null destination discards result and skips dependency check
// RQ12: conditional modifier updates flags even with null destination
// RQ13: send to null destination expects no reply, reserves nothing
// RQ14: line gives src1 times src0 element 0 plus element 3
// RQ15: multiply-accumulate gives src0 times src1 plus accumulator
// RQ16: multiply-accumulate may write the accumulator itself
// RQ17: only moves and selects may read the accumulator
// RQ18: one scoreboard bit per register stalls checked issue
// RQ19: flag bits 0-7 first half, 8-15 second half
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module shader_alu_operand_ops (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // instruction stream
    input wire logic i_valid,
    input wire shader_alu_pkg::instr_s i_instr,
    output logic o_ready,
    // message port
    input wire logic i_reply,
    input wire logic [shader_alu_pkg::REG_W-1:0] i_reply_reg,
    output logic o_send_valid,
    output logic o_send_expect,
    output logic [shader_alu_pkg::REG_W-1:0] o_send_dst,
    output logic [31:0] o_send_data,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    localparam int LN = shader_alu_pkg::LANES;
    localparam int NR = shader_alu_pkg::NREG;

    shader_alu_pkg::instr_s slot;
    logic full;
    logic [31:0] grf [NR][LN];
    logic [31:0] acc [LN];
    logic [LN-1:0] flag;
    logic [NR-1:0] sb;
    logic [NR-1:0] next_sb;
    logic [LN-1:0] next_flag;
    logic misuse;
    logic [6:0] peek_sel;
    logic p_valid, p_write, p_acc, p_clr;
    logic [shader_alu_pkg::REG_W-1:0] p_dst;
    logic [LN-1:0] p_en;
    logic [31:0] p_res [LN];
    logic [31:0] res [LN];
    logic [31:0] s0v [LN];
    logic [31:0] s1v [LN];
    logic [31:0] prod [LN];
    logic [31:0] immv [LN];
    logic [LN-1:0] ex, en;
    logic apb_wr;

    // nibble to single-precision value
    function automatic logic [31:0] nib_flt(input logic [3:0] n);
        case (n)
            4'h0: nib_flt = 32'h00000000;
            4'h1: nib_flt = 32'h3f800000;
            4'h2: nib_flt = 32'h40000000;
            4'h3: nib_flt = 32'h40400000;
            4'h4: nib_flt = 32'h40800000;
            4'h5: nib_flt = 32'h40a00000;
            4'h6: nib_flt = 32'h40c00000;
            4'h7: nib_flt = 32'h40e00000;
            4'h8: nib_flt = 32'hc1000000;
            4'h9: nib_flt = 32'hc0e00000;
            4'ha: nib_flt = 32'hc0c00000;
            4'hb: nib_flt = 32'hc0a00000;
            4'hc: nib_flt = 32'hc0800000;
            4'hd: nib_flt = 32'hc0400000;
            4'he: nib_flt = 32'hc0000000;
            default: nib_flt = 32'hbf800000;
        endcase
    endfunction

    // issue decode
    wire gdst = !slot.dst_null && !slot.dst_acc;
    wire is_send = slot.op == shader_alu_pkg::OP_SEND;
    wire is_move = slot.op == shader_alu_pkg::OP_MOV
        || slot.op == shader_alu_pkg::OP_SEL;
    wire chk = gdst && !slot.skip_scoreboard_check; // RQ9 RQ11
    wire hazard = chk && sb[slot.dst]; // RQ18
    wire go = full && !hazard;
    wire load = i_valid && o_ready;
    wire next_full = load || (full && !go);
    wire bad_acc = go && slot.src0_acc && !is_move; // RQ17
    wire [31:0] k0 = grf[slot.s0][0];
    wire [31:0] k3 = grf[slot.s0][3];

    // per-lane operand decode and compute
    for (genvar c = 0; c < LN; c++) begin : g_lane
        wire [3:0] nib = slot.imm[4*(c%8) +: 4]; // RQ1 RQ2 RQ3
        wire [31:0] isx = {{28{nib[3]}}, nib}; // RQ1
        wire [31:0] sum4 = prod[(c/4)*4] + prod[(c/4)*4+1]
            + prod[(c/4)*4+2] + prod[(c/4)*4+3];
        assign immv[c] = slot.float_dst ? nib_flt(nib) : isx; // RQ4
        assign s0v[c] = slot.src0_acc ? acc[c] : grf[slot.s0][c];
        assign s1v[c] = slot.imm_en ? immv[c] : grf[slot.s1][c];
        assign prod[c] = s0v[c] * s1v[c];
        assign ex[c] = (c < shader_alu_pkg::HALF) || slot.exec16; // RQ19
        // predicate gates writes except for select
        assign en[c] = ex[c] && (!slot.pred || flag[c]
            || slot.op == shader_alu_pkg::OP_SEL); // RQ5 RQ19
        always_comb begin
            case (slot.op)
                shader_alu_pkg::OP_MOV: res[c] = s1v[c];
                shader_alu_pkg::OP_SEL: res[c] =
                    (!slot.pred || flag[c]) ? s0v[c] : s1v[c]; // RQ6
                shader_alu_pkg::OP_ADD: res[c] = s0v[c] + s1v[c];
                shader_alu_pkg::OP_MUL: res[c] = prod[c];
                shader_alu_pkg::OP_LINE: res[c] = s1v[c] * k0 + k3; // RQ14
                shader_alu_pkg::OP_MAC: res[c] = prod[c] + acc[c]; // RQ15
                shader_alu_pkg::OP_DP4: res[c] = sum4; // RQ10
                default: res[c] = 32'h00000000;
            endcase
        end
        // accumulator completion write, gated per channel
        always_ff @(posedge i_clock) begin
            if (p_valid && p_acc && p_en[c]) begin
                acc[c] <= p_res[c]; // RQ16
            end
        end
        // conditional modifier, hardware wins over software write
        assign next_flag[c] = (go && slot.cmod && ex[c] && !is_send)
            ? (res[c] != 32'h00000000) // RQ12
            : (apb_wr && paddr == shader_alu_pkg::OFF_FLAGS)
            ? pwdata[c] : flag[c];
    end

    // register file write; one process owns the whole array
    always_ff @(posedge i_clock) begin
        for (int c = 0; c < LN; c++) begin
            if (p_valid && p_write && p_en[c]) begin
                grf[p_dst][c] <= p_res[c]; // RQ5 RQ11
            end
        end
    end

    // scoreboard: clears first, issue set wins
    always_comb begin
        next_sb = sb;
        if (p_valid && p_clr) begin
            next_sb[p_dst] = 1'b0; // RQ9
        end
        if (i_reply) begin
            next_sb[i_reply_reg] = 1'b0;
        end
        if (go && gdst) begin
            next_sb[slot.dst] = 1'b1; // RQ18 RQ13
        end
    end

    // issue slot and completion stage
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            full <= 1'b0;
            o_ready <= 1'b0;
            sb <= '0;
            p_valid <= 1'b0;
            p_write <= 1'b0;
            p_acc <= 1'b0;
            p_clr <= 1'b0;
        end else begin
            full <= next_full;
            o_ready <= !next_full;
            sb <= next_sb;
            p_valid <= go;
            p_write <= gdst && !is_send; // RQ11
            p_acc <= slot.dst_acc && !is_send;
            p_clr <= gdst && !is_send
                && !slot.skip_scoreboard_clear; // RQ7 RQ8
        end
    end

    // completion data
    always_ff @(posedge i_clock) begin
        if (load) begin
            slot <= i_instr;
        end
        p_dst <= slot.dst;
        p_en <= en;
        p_res <= res;
    end

    // message out; null destination means no reply expected
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_send_valid <= 1'b0;
            o_send_expect <= 1'b0;
            o_send_dst <= '0;
            o_send_data <= 32'h00000000;
        end else begin
            o_send_valid <= go && is_send;
            o_send_expect <= gdst; // RQ13
            o_send_dst <= slot.dst;
            o_send_data <= s0v[0];
        end
    end

    // apb decode
    wire apb_req = psel && penable && !pready;
    assign apb_wr = psel && penable && pready && pwrite;
    wire [3:0] pk_lane = peek_sel[shader_alu_pkg::PEEK_LANE_LSB +: 4];
    wire [2:0] pk_reg = peek_sel[shader_alu_pkg::PEEK_REG_LSB +: 3];
    wire hit = paddr == shader_alu_pkg::OFF_FLAGS
        || paddr == shader_alu_pkg::OFF_SCORE
        || paddr == shader_alu_pkg::OFF_STATUS
        || paddr == shader_alu_pkg::OFF_PEEK_SEL
        || paddr == shader_alu_pkg::OFF_PEEK;
    wire [31:0] rd_mux =
        paddr == shader_alu_pkg::OFF_FLAGS ? {16'h0000, flag} :
        paddr == shader_alu_pkg::OFF_SCORE ? {24'h000000, sb} :
        paddr == shader_alu_pkg::OFF_STATUS ?
            {30'h0, full, misuse} :
        paddr == shader_alu_pkg::OFF_PEEK_SEL ? {25'h0, peek_sel} :
        paddr == shader_alu_pkg::OFF_PEEK ? grf[pk_reg][pk_lane] :
        32'h00000000;
    wire clr_misuse = apb_wr && paddr == shader_alu_pkg::OFF_STATUS
        && pwdata[shader_alu_pkg::ST_MISUSE];

    // apb registers, one wait state
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            flag <= shader_alu_pkg::FLAGS_RST;
            misuse <= 1'b0;
            peek_sel <= shader_alu_pkg::PEEK_SEL_RST;
        end else begin
            pready <= apb_req;
            pslverr <= apb_req && !hit;
            prdata <= apb_req && !pwrite ? rd_mux : 32'h00000000;
            flag <= next_flag;
            misuse <= bad_acc || (misuse && !clr_misuse); // RQ17
            if (apb_wr && paddr == shader_alu_pkg::OFF_PEEK_SEL) begin
                peek_sel <= pwdata[6:0];
            end
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    sequence s_keep_issue;
        go && gdst && slot.skip_scoreboard_clear && !is_send;
    endsequence

    chk_nibble_lane0: assert property ( // RQ1 RQ2
        !slot.float_dst |-> immv[0] == {{28{slot.imm[3]}}, slot.imm[3:0]}
    ) else $error("lane 0 immediate wrong");
    chk_nibble_top: assert property ( // RQ2 RQ3
        !slot.float_dst |-> immv[15] == {{28{slot.imm[31]}}, slot.imm[31:28]}
    ) else $error("lane 15 immediate wrong");
    chk_float_minus: assert property ( // RQ4
        slot.float_dst && slot.imm[7:4] == 4'hf
        |-> immv[1] == shader_alu_pkg::F_MINUS_ONE
    ) else $error("float nibble f not minus one");
    chk_pred_mask: assert property ( // RQ5 RQ19
        go && slot.op == shader_alu_pkg::OP_MOV && slot.pred && slot.exec16
        |=> p_en == $past(flag)
    ) else $error("predicated move mask wrong");
    chk_sel_pick: assert property ( // RQ6
        go && slot.op == shader_alu_pkg::OP_SEL && slot.pred && !flag[2]
        |-> res[2] == s1v[2]
    ) else $error("select picked wrong source");
    chk_keep_set: assert property ( // RQ7
        s_keep_issue ##1 !i_reply [*2] |-> sb[$past(slot.dst, 2)]
    ) else $error("scoreboard bit cleared despite option");
    chk_clear_done: assert property ( // RQ9
        go && gdst && !is_send && !slot.skip_scoreboard_clear
        |=> p_clr ##1 (!sb[$past(slot.dst, 2)] || $past(go && gdst))
    ) else $error("scoreboard bit not cleared");
    chk_dp4_repl: assert property ( // RQ10
        go && slot.op == shader_alu_pkg::OP_DP4
        |-> res[1] == res[0] && res[3] == res[0] && res[7] == res[4]
    ) else $error("dot product not replicated");
    chk_null_issue: assert property ( // RQ11 RQ18
        full && (slot.dst_null || !chk) |-> go ##1 !full
    ) else $error("null or unchecked instruction stalled");
    chk_stall_hold: assert property ( // RQ18
        full && chk && sb[slot.dst] |=> full && !o_ready
    ) else $error("hazard did not stall");
    chk_flag_cmod: assert property ( // RQ12
        go && slot.cmod && !is_send |=> flag[0] == ($past(res[0]) != 0)
    ) else $error("flag not updated by modifier");
    chk_send_null: assert property ( // RQ13
        go && is_send && slot.dst_null |=> o_send_valid && !o_send_expect
    ) else $error("null send expects reply");
endmodule // shader_alu_operand_ops

/* File: rtl/shader_alu_pkg.sv */
// Purpose: shared constants and types for the shader operand datapath
// Assumes: 16 lanes of 32 bits, 8 general registers
// Notes: register byte offsets on the APB port
package shader_alu_pkg;
    localparam int LANES = 16;
    localparam int HALF = 8;
    localparam int REG_W = 3;
    localparam int NREG = 8;
    // apb byte offsets
    localparam logic [7:0] OFF_FLAGS = 8'h00;
    localparam logic [7:0] OFF_SCORE = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_PEEK_SEL = 8'h0c;
    localparam logic [7:0] OFF_PEEK = 8'h10;
    // field positions
    localparam int ST_MISUSE = 0;
    localparam int ST_BUSY = 1;
    localparam int PEEK_LANE_LSB = 0;
    localparam int PEEK_REG_LSB = 4;
    // reset values and the float minus one constant
    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [6:0] PEEK_SEL_RST = 7'h00;
    localparam logic [31:0] F_MINUS_ONE = 32'hbf800000;

    typedef enum logic [2:0] {
        OP_MOV, OP_SEL, OP_ADD, OP_MUL, OP_LINE, OP_MAC, OP_DP4, OP_SEND
    } op_e;

    typedef struct packed {
        op_e op;
        logic exec16;
        logic pred;
        logic cmod;
        logic imm_en;
        logic float_dst;
        logic src0_acc;
        logic skip_scoreboard_clear;
        logic skip_scoreboard_check;
        logic dst_null;
        logic dst_acc;
        logic [REG_W-1:0] dst;
        logic [REG_W-1:0] s0;
        logic [REG_W-1:0] s1;
        logic [31:0] imm;
    } instr_s;
endpackage

/* File: sim/tb_shader_alu_operand_ops.sv */
// Purpose: self-checking bench for the shader operand datapath
// Assumes: the apb peek port exposes every register lane
// Notes: expectations come from a bench-side mirror of the registers
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_shader_alu_operand_ops;
    // stimulus, observed outputs and bench state
    logic i_clock, i_nrst, i_valid, i_reply, psel, penable, pwrite;
    logic o_ready, o_send_valid, o_send_expect, pready, pslverr, sexp, er;
    logic [2:0] i_reply_reg, o_send_dst, sdst;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, o_send_data, sdata, rd, imm;
    logic [15:0] fl;
    logic [31:0] m [8][16];
    shader_alu_pkg::instr_s i_instr, x;
    int n_fail, num_checks, cyc, seed, i, l;

    shader_alu_operand_ops DUT (.i_clock(i_clock), .i_nrst(i_nrst),
        .i_valid(i_valid), .i_instr(i_instr), .o_ready(o_ready),
        .i_reply(i_reply), .i_reply_reg(i_reply_reg),
        .o_send_valid(o_send_valid), .o_send_expect(o_send_expect),
        .o_send_dst(o_send_dst), .o_send_data(o_send_data), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // 100 ns clock
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    // watchdog and capture of the one-cycle send pulse
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            tally_and_finish();
        end
        if (o_send_valid === 1'b1) begin
            sexp <= o_send_expect;
            sdst <= o_send_dst;
            sdata <= o_send_data;
        end
    end

    // expected lane of a vector immediate, integer or float
    function automatic logic [31:0] nib(input logic [31:0] v, input int k,
            input logic f);
        logic [3:0] n;
        int a, e;
        n = v[4*(k%8) +: 4];
        a = $signed(n);
        if (!f) return 32'(a);
        if (a == 0) return 32'h0;
        e = 0;
        while (((a < 0 ? -a : a) >> (e + 1)) != 0) e++;
        return {a < 0, 8'(127 + e), 23'((a < 0 ? -a : a) << (23 - e))};
    endfunction

    function automatic shader_alu_pkg::instr_s mk(
            input shader_alu_pkg::op_e op, input logic [2:0] d,
            input logic [2:0] a, input logic [2:0] b, input logic [31:0] v);
        shader_alu_pkg::instr_s y;
        y = '0;
        y.op = op;
        y.exec16 = 1'b1;
        y.dst = d;
        y.s0 = a;
        y.s1 = b;
        y.imm = v;
        return y;
    endfunction

    // apb transfer: hold until pready seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge i_clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        do @(posedge i_clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("register", e, rd)
    endtask

    task automatic cmp_reg(input int r);
        for (int k = 0; k < 16; k++) begin
            apb(1'b1, shader_alu_pkg::OFF_PEEK_SEL, 32'(r * 16 + k));
            rdchk(shader_alu_pkg::OFF_PEEK, m[r][k]);
        end
    endtask

    task automatic setfl(input logic [7:0] lo);
        fl = 16'($random(seed));
        fl[7:0] = lo;
        apb(1'b1, shader_alu_pkg::OFF_FLAGS, {16'h0, fl});
    endtask

    // instruction offer held until taken, then valid dropped
    task automatic offer(input shader_alu_pkg::instr_s v);
        i_instr <= v;
        i_valid <= 1'b1;
        do @(posedge i_clock); while (o_ready !== 1'b1);
        i_valid <= 1'b0;
    endtask

    task automatic settle();
        do @(posedge i_clock); while (o_ready !== 1'b1);
    endtask

    task automatic run(input shader_alu_pkg::instr_s v);
        offer(v);
        settle();
    endtask

    task automatic stall_then_reply(input logic [2:0] r);
        repeat (6) @(posedge i_clock);
        `CHK("stall", 1'b0, o_ready)
        i_reply_reg <= r;
        i_reply <= 1'b1;
        @(posedge i_clock);
        i_reply <= 1'b0;
        settle();
    endtask

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        seed = 26;
        i_nrst = 1'b0;
        i_valid = 1'b0;
        i_instr = '0;
        i_reply = 1'b0;
        i_reply_reg = 3'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge i_clock);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_clock);
        rdchk(shader_alu_pkg::OFF_FLAGS, 32'(shader_alu_pkg::FLAGS_RST));
        rdchk(shader_alu_pkg::OFF_SCORE, 32'h0);
        rdchk(shader_alu_pkg::OFF_PEEK_SEL,
            32'(shader_alu_pkg::PEEK_SEL_RST));
        rdchk(8'h14, 32'h0);
        `CHK("slverr", 1'b1, er)
        done("registers");
        for (i = 0; i < 5; i++) begin
            imm = (i == 0) ? 32'h000f000f : (i == 1) ? 32'h8f7f0123
                : $random(seed);
            x = mk(shader_alu_pkg::OP_MOV, 3'(i), 3'h0, 3'h0, imm);
            x.imm_en = 1'b1;
            x.float_dst = ~i[0];
            run(x);
            for (l = 0; l < 16; l++) m[i][l] = nib(imm, l, ~i[0]);
            cmp_reg(i);
        end
        done("immediates");
        setfl(8'h99);
        imm = $random(seed);
        x = mk(shader_alu_pkg::OP_MOV, 3'h1, 3'h0, 3'h0, imm);
        x.imm_en = 1'b1;
        x.pred = 1'b1;
        run(x);
        for (l = 0; l < 16; l++) if (fl[l]) m[1][l] = nib(imm, l, 1'b0);
        cmp_reg(1);
        setfl(8'h66);
        x = mk(shader_alu_pkg::OP_SEL, 3'h5, 3'h3, 3'h0, imm);
        x.imm_en = 1'b1;
        x.pred = 1'b1;
        run(x);
        for (l = 0; l < 16; l++) m[5][l] = fl[l] ? m[3][l] : nib(imm, l, 0);
        cmp_reg(5);
        done("predication");
        run(mk(shader_alu_pkg::OP_SEND, 3'h6, 3'h1, 3'h0, 32'h0));
        rdchk(shader_alu_pkg::OFF_SCORE, 32'h40);
        `CHK("expect", 1'b1, sexp)
        `CHK("send_dst", 3'h6, sdst)
        `CHK("send_data", m[1][0], sdata)
        apb(1'b1, shader_alu_pkg::OFF_FLAGS, 32'h0);
        x = mk(shader_alu_pkg::OP_ADD, 3'h6, 3'h1, 3'h3, 32'h0);
        x.dst_null = 1'b1;
        x.cmod = 1'b1;
        run(x);
        for (l = 0; l < 16; l++) fl[l] = (m[1][l] + m[3][l]) != 32'h0;
        rdchk(shader_alu_pkg::OFF_FLAGS, {16'h0, fl});
        x = mk(shader_alu_pkg::OP_SEND, 3'h2, 3'h1, 3'h0, 32'h0);
        x.dst_null = 1'b1;
        run(x);
        rdchk(shader_alu_pkg::OFF_SCORE, 32'h40);
        `CHK("expect", 1'b0, sexp)
        offer(mk(shader_alu_pkg::OP_MOV, 3'h6, 3'h0, 3'h3, 32'h0));
        stall_then_reply(3'h6);
        for (l = 0; l < 16; l++) m[6][l] = m[3][l];
        cmp_reg(6);
        done("scoreboard");
        x = mk(shader_alu_pkg::OP_DP4, 3'h7, 3'h1, 3'h3, 32'h0);
        x.skip_scoreboard_clear = 1'b1;
        run(x);
        rdchk(shader_alu_pkg::OFF_SCORE, 32'h80);
        offer(x);
        stall_then_reply(3'h7);
        x.skip_scoreboard_check = 1'b1;
        run(x);
        rdchk(shader_alu_pkg::OFF_SCORE, 32'h80);
        x.skip_scoreboard_clear = 1'b0;
        run(x);
        rdchk(shader_alu_pkg::OFF_SCORE, 32'h0);
        for (l = 0; l < 16; l++) begin
            imm = 32'h0;
            for (int k = l / 4 * 4; k < l / 4 * 4 + 4; k++)
                imm += m[1][k] * m[3][k];
            m[7][l] = imm;
        end
        cmp_reg(7);
        done("dot product");
        x = mk(shader_alu_pkg::OP_LINE, 3'h0, 3'h1, 3'h3, 32'h0);
        x.dst_acc = 1'b1;
        run(x);
        x.op = shader_alu_pkg::OP_MAC;
        run(x);
        run(mk(shader_alu_pkg::OP_MAC, 3'h2, 3'h3, 3'h1, 32'h0));
        for (l = 0; l < 16; l++)
            m[2][l] = 2 * m[1][l] * m[3][l] + m[3][l] * m[1][0] + m[1][3];
        cmp_reg(2);
        done("accumulate");
        x = mk(shader_alu_pkg::OP_SEL, 3'h0, 3'h1, 3'h1, 32'h0);
        x.dst_null = 1'b1;
        x.src0_acc = 1'b1;
        run(x);
        rdchk(shader_alu_pkg::OFF_STATUS, 32'h0);
        x.op = shader_alu_pkg::OP_ADD;
        run(x);
        rdchk(shader_alu_pkg::OFF_STATUS, 32'h1);
        apb(1'b1, shader_alu_pkg::OFF_STATUS, 32'h1);
        rdchk(shader_alu_pkg::OFF_STATUS, 32'h0);
        done("misuse");
        tally_and_finish();
    end
endmodule // tb_shader_alu_operand_ops
